// ===== rtl/por_seq_defs.vh
/*
 holds the constants of the reset and power sequencer: state codes and timing.
 assumes a 100 MHz system clock standing in for the on-chip oscillator.
*/
`ifndef POR_SEQ_DEFS_VH
`define POR_SEQ_DEFS_VH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 10
`define STRETCH_TIME_MS 50
`define STRETCH_MIN_MS 34
`define STRETCH_MAX_MS 102
`define STARTUP_LIMIT_MS 60
`define STRETCH_CYCLES ((`STRETCH_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define INIT_SETTLE_CYCLES 16
`define SYNC_STAGES 2

// ****************************************
// state codes
// ****************************************
`define ST_RESET 3'h0
`define ST_INIT 3'h1
`define ST_CMD 3'h2
`define ST_ACTIVE 3'h3
`define ST_SLEEP 3'h4

// ****************************************
// reset values
// ****************************************
`define SWM_WIDTH 7
`define SWM_OFF_RST 7'h7F

`endif

// ===== rtl/sync_cell.v
/*
 holds a multi-bit two-flop synchroniser used on the asynchronous pins.
 assumes each bit is an independent level; no bus coherence is kept.
*/
`timescale 1ns/1ps
module sync_cell #(
   parameter WIDTH = 2,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // data
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] q_reg;

   // the first stage feeds only the second stage
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule

// ===== rtl/power_on_reset_sequencer.v
/*
 holds the power unit sequencer: stretched start-up reset, supply dip reset,
 external reset override, crystal gating, switch-matrix enables and the
 reset/init/command/active/sleep state machine.
 assumes sys_clk_i is the free-running on-chip oscillator and that the analog
 detectors deliver levels; the chip reset pin is open-drain with a weak pull.
*/
// How it works
// - state machine with sleep; wakes on startup reset, low-power timer or service request
// - startup reset stretched about 50 ms, within 34 to 102 ms
// - startup reset always enabled, resets everything including this unit
// - supply below threshold drives reset line low, then full stretch follows
// - chip reset line held weakly high when no reset is asserted
// - every supply dip detector can force the full chip reset
// - crystal stays off after reset until boot, then firmware alone controls it
// - internal reference is 16 MHz for either crystal size
// - processor starts the boot program on entry to the command handler, only after init sees service request high
// - fixed start-up interval stays below 60 ms
// - switch-matrix pins 5 to 11 stay disabled until host command enables
// - init samples service request: low stays, high enters command handler
// - init entered only from reset after startup reset settles
// - sleep returns to active on a service request transition
`timescale 1ns/1ps
`include "por_seq_defs.vh"
module power_on_reset_sequencer #(
   parameter DIP_COUNT = 2,
   parameter STRETCH_CYCLES = `STRETCH_CYCLES,
   parameter INIT_CYCLES = `INIT_SETTLE_CYCLES
) (
   // clock and reset
   input wire sys_clk_i,
   input wire arst_n_i,
   // analog detectors
   input wire core_supply_low_i,
   input wire [DIP_COUNT-1:0] supply_dip_detector_i,
   input wire [DIP_COUNT-1:0] dip_reset_enable_i,
   // open-drain chip reset line
   input wire chip_reset_line_n_i,
   output wire chip_reset_line_n_o,
   output wire chip_reset_line_n_oe_n_o,
   // host side
   input wire service_request_pin_i,
   input wire swm_enable_cmd_i,
   input wire [`SWM_WIDTH-1:0] swm_enable_mask_i,
   // firmware controls
   input wire xtal_enable_i,
   input wire xtal_32m_sel_i,
   input wire lp_timer_expired_i,
   input wire boot_done_i,
   input wire start_app_i,
   input wire sleep_cmd_i,
   input wire fw_reset_i,
   // outputs
   output reg startup_reset_line_n_o,
   output reg core_reset_n_o,
   output reg boot_start_o,
   output reg xtal_enable_o,
   output reg ref_div_half_o,
   output reg [`SWM_WIDTH-1:0] swm_tristate_o,
   output reg [2:0] state_o,
   output reg wake_o
);
   // ****************************************
   // reset sources
   // ****************************************
   wire [1:0] sync_q;
   wire srq_sync;
   wire ext_rst_n_sync;
   reg srq_prev_reg;
   reg [31:0] stretch_cnt_reg;
   reg [31:0] stretch_cnt_next;
   reg stretch_done_reg;
   wire any_reset;

   sync_cell #(.WIDTH(2), .RST_VAL(2'h0)) u_sync (
      .clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .d_i({service_request_pin_i, chip_reset_line_n_i}),
      .q_o(sync_q)
   );
   assign srq_sync = sync_q[1];
   assign ext_rst_n_sync = sync_q[0];

   wire [DIP_COUNT-1:0] dip_force;
   wire dip_any;
   reg startup_req_reg;
   reg line_oe_n_reg;

   // ****************************************
   // supply dip detectors
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < DIP_COUNT; gi = gi + 1) begin : g_dip
         // a detector forces reset only while its enable is set
         assign dip_force[gi] = supply_dip_detector_i[gi] & dip_reset_enable_i[gi];
      end
   endgenerate
   assign dip_any = |dip_force;

   assign any_reset = core_supply_low_i
      | dip_any
      | fw_reset_i
      | ~ext_rst_n_sync;

   // weak pull modelled by releasing the pin; only reset drives it low
   assign chip_reset_line_n_o = 1'b0;
   // enable comes from a flop so the pin never glitches
   assign chip_reset_line_n_oe_n_o = line_oe_n_reg;

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         startup_req_reg <= 1'b1;
         line_oe_n_reg <= 1'b0;
      end else begin
         startup_req_reg <= core_supply_low_i | dip_any;
         line_oe_n_reg <= ~startup_req_reg;
      end
   end

   always @* begin
      stretch_cnt_next = stretch_cnt_reg;
      if (any_reset) begin
         stretch_cnt_next = 32'h0;
      end else if (!stretch_done_reg) begin
         stretch_cnt_next = stretch_cnt_reg + 32'h1;
      end
   end

   // the asynchronous reset clears this unit entirely
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stretch_cnt_reg <= 32'h0;
         stretch_done_reg <= 1'b0;
      end else begin
         stretch_cnt_reg <= stretch_cnt_next;
         stretch_done_reg <= !any_reset && (stretch_cnt_next >= STRETCH_CYCLES);
      end
   end

   // ****************************************
   // state machine
   // ****************************************
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] init_cnt_reg;
   reg xtal_allowed_reg;
   reg [`SWM_WIDTH-1:0] swm_off_reg;
   wire srq_edge;
   wire init_settled;

   assign srq_edge = srq_sync ^ srq_prev_reg;
   assign init_settled = (init_cnt_reg >= INIT_CYCLES);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_RESET: begin
            if (stretch_done_reg) begin
               state_next = `ST_INIT;
            end
         end
         `ST_INIT: begin
            // stays while the pin is low
            if (init_settled && srq_sync) begin
               state_next = `ST_CMD;
            end
         end
         `ST_CMD: begin
            if (start_app_i) begin
               state_next = `ST_ACTIVE;
            end
         end
         `ST_ACTIVE: begin
            if (sleep_cmd_i) begin
               state_next = `ST_SLEEP;
            end
         end
         `ST_SLEEP: begin
            if (srq_edge || lp_timer_expired_i) begin
               state_next = `ST_ACTIVE;
            end
         end
         default: begin
            state_next = `ST_RESET;
         end
      endcase
      if (!stretch_done_reg) begin
         state_next = `ST_RESET;
      end
   end

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= `ST_RESET;
         srq_prev_reg <= 1'b0;
         init_cnt_reg <= 8'h00;
         xtal_allowed_reg <= 1'b0;
         swm_off_reg <= `SWM_OFF_RST;
      end else begin
         state_reg <= state_next;
         srq_prev_reg <= srq_sync;
         if (state_reg == `ST_INIT) begin
            if (!init_settled) begin
               init_cnt_reg <= init_cnt_reg + 8'h01;
            end
         end else begin
            init_cnt_reg <= 8'h00;
         end
         // unlocked once boot completes, cleared by any reset
         if (!stretch_done_reg) begin
            xtal_allowed_reg <= 1'b0;
         end else if (boot_done_i && state_reg != `ST_RESET && state_reg != `ST_INIT) begin
            xtal_allowed_reg <= 1'b1;
         end
         if (!stretch_done_reg) begin
            swm_off_reg <= `SWM_OFF_RST;
         end else if (swm_enable_cmd_i && state_reg != `ST_RESET && state_reg != `ST_INIT) begin
            swm_off_reg <= ~swm_enable_mask_i;
         end
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         startup_reset_line_n_o <= 1'b0;
         core_reset_n_o <= 1'b0;
         boot_start_o <= 1'b0;
         xtal_enable_o <= 1'b0;
         ref_div_half_o <= 1'b0;
         swm_tristate_o <= `SWM_OFF_RST;
         state_o <= `ST_RESET;
         wake_o <= 1'b0;
      end else begin
         startup_reset_line_n_o <= ~startup_req_reg;
         core_reset_n_o <= stretch_done_reg;
         // one pulse on entry to the command handler
         boot_start_o <= (state_reg == `ST_INIT) && (state_next == `ST_CMD);
         xtal_enable_o <= xtal_allowed_reg & xtal_enable_i;
         // halve a 32 MHz crystal so logic always sees 16 MHz
         ref_div_half_o <= xtal_32m_sel_i;
         swm_tristate_o <= swm_off_reg;
         state_o <= state_next;
         wake_o <= (state_reg == `ST_SLEEP) && (state_next == `ST_ACTIVE);
      end
   end
endmodule

// ===== bench/por_seq_checker.sv
/* assertions on the power sequencer ports.
 assumes the bind at the foot and one clock domain. */
`timescale 1ns/1ps
module por_seq_checker #(
   parameter DIP_COUNT = 2,
   parameter STRETCH_CYCLES = 20
) (
   // clock, reset and causes
   input wire sys_clk_i,
   input wire arst_n_i,
   input wire core_supply_low_i,
   input wire [DIP_COUNT-1:0] supply_dip_detector_i,
   input wire [DIP_COUNT-1:0] dip_reset_enable_i,
   input wire service_request_pin_i,
   input wire swm_enable_cmd_i,
   // watched outputs
   input wire chip_reset_line_n_oe_n_o,
   input wire startup_reset_line_n_o,
   input wire core_reset_n_o,
   input wire xtal_enable_o,
   input wire [6:0] swm_tristate_o,
   input wire [2:0] state_o
);
   // ******
   // helpers
   // ******
   reg [31:0] low_cnt_reg;
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i || core_reset_n_o) begin
         low_cnt_reg <= 32'h0;
      end else begin
         low_cnt_reg <= low_cnt_reg + 32'h1;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence dip_hit;
      |(supply_dip_detector_i & dip_reset_enable_i);
   endsequence
   sequence init_entry;
      $past(state_o) != 3'h1 ##0 state_o == 3'h1;
   endsequence
   // srq low over the whole sync window leaves no way into the command handler
   sequence srq_low4;
      !service_request_pin_i [*4] ##0 $past(state_o) == 3'h1;
   endsequence
   // ******
   // assertions
   // ******
   AST_STRETCH: assert property ($rose(core_reset_n_o) |-> low_cnt_reg >= STRETCH_CYCLES)
      else $error("core reset released early");
   AST_INIT_ENTRY: assert property (init_entry |-> $past(state_o) == 3'h0)
      else $error("init entered from a state other than reset");
   AST_INIT_HOLD: assert property (srq_low4 |-> state_o != 3'h2)
      else $error("left init while srq low");
   AST_SUPPLY: assert property (core_supply_low_i |->
      ##[1:3] (!startup_reset_line_n_o && !chip_reset_line_n_oe_n_o))
      else $error("supply low did not pull reset line");
   AST_DIP: assert property (dip_hit |-> ##[1:4] !core_reset_n_o)
      else $error("dip detector did not force reset");
   AST_PIN: assert property ($rose(core_reset_n_o) |-> chip_reset_line_n_oe_n_o)
      else $error("reset line still pulled after release");
   AST_XTAL: assert property ($rose(xtal_enable_o) |-> core_reset_n_o && state_o > 3'h1)
      else $error("crystal enabled before boot");
   AST_SWM: assert property (|($past(swm_tristate_o) & ~swm_tristate_o) |->
      $past(swm_enable_cmd_i, 2))
      else $error("switch pin enabled without command");
endmodule
bind power_on_reset_sequencer por_seq_checker #(.DIP_COUNT(DIP_COUNT),
   .STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (.sys_clk_i, .arst_n_i, .core_supply_low_i,
   .supply_dip_detector_i, .dip_reset_enable_i, .service_request_pin_i, .swm_enable_cmd_i,
   .chip_reset_line_n_oe_n_o, .startup_reset_line_n_o, .core_reset_n_o, .xtal_enable_o,
   .swm_tristate_o, .state_o);

// ===== bench/host_model.sv
/* host side: service request pin and an open-drain pull on the chip reset line.
 assumes a weak pull-up on the line; drives on the falling clock edge. */
`timescale 1ns/1ps
module host_model (
   // clock
   input wire sys_clk_i,
   // pins
   input wire dev_oe_n_i,
   output wire line_n_o,
   output reg srq_o
);
   reg pull_reg;
   // host only pulls low or lets go; the pull-up gives the high level
   assign line_n_o = (!dev_oe_n_i || pull_reg) ? 1'b0 : 1'b1;
   initial begin
      pull_reg = 1'b0;
      srq_o = 1'b0;
   end
   task pull_reset(input integer n);
      begin
         @(negedge sys_clk_i) pull_reg = 1'b1;
         repeat (n) @(negedge sys_clk_i);
         pull_reg = 1'b0;
      end
   endtask
   task set_srq(input logic v);
      @(negedge sys_clk_i) srq_o = v;
   endtask
endmodule

// ===== bench/tb.sv
/* self-checking bench of the power sequencer with a short stretch count.
 assumes host_model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "por_seq_defs.vh"
module tb;
   localparam SC = 20;
   reg sys_clk_i, arst_n_i, core_supply_low_i, fw_reset_i, swm_enable_cmd_i, xtal_enable_i;
   reg xtal_32m_sel_i, lp_timer_expired_i, boot_done_i, start_app_i, sleep_cmd_i;
   reg [1:0] supply_dip_detector_i, dip_reset_enable_i;
   reg [6:0] swm_enable_mask_i;
   wire chip_reset_line_n_i, service_request_pin_i, chip_reset_line_n_o;
   wire chip_reset_line_n_oe_n_o, startup_reset_line_n_o, core_reset_n_o, boot_start_o;
   wire xtal_enable_o, ref_div_half_o, wake_o;
   wire [6:0] swm_tristate_o;
   wire [2:0] state_o;
   integer err_count, num_checks, n, k;
   power_on_reset_sequencer #(.DIP_COUNT(2), .STRETCH_CYCLES(SC), .INIT_CYCLES(16)) u_dut (
      .sys_clk_i, .arst_n_i, .core_supply_low_i, .supply_dip_detector_i, .dip_reset_enable_i,
      .chip_reset_line_n_i, .chip_reset_line_n_o, .chip_reset_line_n_oe_n_o,
      .service_request_pin_i, .swm_enable_cmd_i, .swm_enable_mask_i, .xtal_enable_i,
      .xtal_32m_sel_i, .lp_timer_expired_i, .boot_done_i, .start_app_i, .sleep_cmd_i,
      .fw_reset_i, .startup_reset_line_n_o, .core_reset_n_o, .boot_start_o, .xtal_enable_o,
      .ref_div_half_o, .swm_tristate_o, .state_o, .wake_o);
   host_model u_host (.sys_clk_i, .dev_oe_n_i(chip_reset_line_n_oe_n_o),
      .line_n_o(chip_reset_line_n_i), .srq_o(service_request_pin_i));
   task tick(input integer c);
      repeat (c) @(negedge sys_clk_i);
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   // bounded wait; running out counts a mismatch and ends the run
   task wait_state(input logic [2:0] s);
      begin
         n = 0;
         while (state_o !== s && n < 400) begin
            tick(1);
            n = n + 1;
         end
         if (n == 400) begin
            chk(state_o, s, "state wait");
            test_done;
         end
      end
   endtask
   task t_boot;
      begin
         wait_state(`ST_INIT);
         chk(n >= SC && n <= SC + 8, 1, "stretch length");
         chk(xtal_enable_o, 0, "xtal after reset");
         swm_enable_cmd_i = 1'b1;
         tick(1);
         swm_enable_cmd_i = 1'b0;
         tick(30);
         chk(state_o, `ST_INIT, "init with srq low");
         chk(swm_tristate_o, 7'h7F, "swm before boot");
         u_host.set_srq(1'b1);
         wait_state(`ST_CMD);
         chk(boot_start_o, 1, "boot start");
         xtal_enable_i = 1'b1;
         xtal_32m_sel_i = 1'b1;
         tick(3);
         chk(xtal_enable_o, 0, "xtal before boot done");
         chk(ref_div_half_o, 1, "ref divider");
         boot_done_i = 1'b1;
         tick(3);
         chk(xtal_enable_o, 1, "xtal on");
         xtal_enable_i = 1'b0;
         swm_enable_cmd_i = 1'b1;
         tick(1);
         swm_enable_cmd_i = 1'b0;
         tick(3);
         chk(xtal_enable_o, 0, "xtal off");
         chk(swm_tristate_o, 7'h7A, "swm enabled");
      end
   endtask
   task t_modes;
      begin
         start_app_i = 1'b1;
         tick(1);
         start_app_i = 1'b0;
         wait_state(`ST_ACTIVE);
         for (k = 0; k < 2; k = k + 1) begin
            sleep_cmd_i = 1'b1;
            tick(1);
            sleep_cmd_i = 1'b0;
            wait_state(`ST_SLEEP);
            tick(5);
            chk(state_o, `ST_SLEEP, "sleep held");
            if (k == 0) u_host.set_srq(1'b0);
            else lp_timer_expired_i = 1'b1;
            tick(1);
            lp_timer_expired_i = 1'b0;
            wait_state(`ST_ACTIVE);
            chk(wake_o, 1, "wake pulse");
         end
      end
   endtask
   task t_resets;
      for (k = 0; k < 4; k = k + 1) begin
         core_supply_low_i = (k == 0);
         supply_dip_detector_i = {k == 1, 1'b0};
         fw_reset_i = (k == 2);
         if (k == 3) u_host.pull_reset(5);
         else tick(5);
         chk(core_reset_n_o, 0, "core reset");
         chk(chip_reset_line_n_oe_n_o, k > 1, "pin pull");
         chk(startup_reset_line_n_o, k > 1, "startup line");
         chk(chip_reset_line_n_o, 0, "pin data");
         core_supply_low_i = 1'b0;
         supply_dip_detector_i = 2'h0;
         fw_reset_i = 1'b0;
         tick(SC / 2);
         fw_reset_i = 1'b1;
         tick(2);
         fw_reset_i = 1'b0;
         wait_state(`ST_INIT);
         chk(n >= SC && n <= SC + 8, 1, "restarted stretch");
      end
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      {arst_n_i, core_supply_low_i, fw_reset_i, swm_enable_cmd_i, xtal_enable_i} = 5'h0;
      {xtal_32m_sel_i, lp_timer_expired_i, boot_done_i, start_app_i, sleep_cmd_i} = 5'h0;
      supply_dip_detector_i = 2'h0;
      dip_reset_enable_i = 2'h2;
      swm_enable_mask_i = 7'h05;
      err_count = 0;
      num_checks = 0;
      tick(10);
      arst_n_i = 1'b1;
      t_boot;
      t_modes;
      t_resets;
      test_done;
   end
endmodule
